// File: logic/ssq_pkg.sv
// constants and types for the sequencer stack and core register block
package ssq_pkg;
  localparam int PC_DEPTH   = 33;
  localparam int LOOP_DEPTH = 8;
  localparam int CNT_DEPTH  = 8;
  localparam int SB_W       = 5;
  localparam int SE_W       = 8;
  localparam logic [15:0] IRQ_RST  = 16'h0000;
  localparam logic [7:0]  INDIRECT_JUMP_PAGE_RST = 8'h00;
  // register group codes
  localparam logic [1:0] G_DREG = 2'h0;
  localparam logic [1:0] G_REG1 = 2'h1;
  localparam logic [1:0] G_REG2 = 2'h2;
  localparam logic [1:0] G_REG3 = 2'h3;
  // data register file addresses
  localparam logic [3:0] A_AX0 = 4'h0;
  localparam logic [3:0] A_AX1 = 4'h1;
  localparam logic [3:0] A_MX0 = 4'h2;
  localparam logic [3:0] A_MX1 = 4'h3;
  localparam logic [3:0] A_AY0 = 4'h4;
  localparam logic [3:0] A_AY1 = 4'h5;
  localparam logic [3:0] A_MY0 = 4'h6;
  localparam logic [3:0] A_MY1 = 4'h7;
  localparam logic [3:0] A_MR2 = 4'h8;
  localparam logic [3:0] A_SR2 = 4'h9;
  localparam logic [3:0] A_AR  = 4'hA;
  localparam logic [3:0] A_SI  = 4'hB;
  localparam logic [3:0] A_MR1 = 4'hC;
  localparam logic [3:0] A_SR1 = 4'hD;
  localparam logic [3:0] A_MR0 = 4'hE;
  localparam logic [3:0] A_SR0 = 4'hF;
  // group 1 to 3 addresses
  localparam logic [3:0] A_IRQ_MASK_REG = 4'hC;
  localparam logic [3:0] A_IRQ_LATCH_REG = 4'hD;
  localparam logic [3:0] A_IRQ_CONTROL_REG = 4'hE;
  localparam logic [3:0] A_PADDR = 4'hF;
  localparam logic [3:0] A_LOOP_COUNTER  = 4'hE;
  localparam logic [3:0] A_LADDR = 4'hF;
  localparam logic [3:0] A_LPAGE = 4'h3;
  localparam logic [3:0] A_SE    = 4'h5;
  localparam logic [3:0] A_SB    = 4'h6;
  localparam logic [3:0] A_PX    = 4'h7;
  localparam logic [3:0] A_INDIRECT_JUMP_PAGE  = 4'hB;
  localparam logic [3:0] A_PPAGE = 4'hF;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_JUMP = 4'h1, OP_CALL = 4'h2, OP_LOOP = 4'h3,
    OP_PUSH_PC = 4'h4, OP_RTS = 4'h5, OP_RTI = 4'h6, OP_POP_PC = 4'h7,
    OP_PUSH_LOOP = 4'h8, OP_POP_LOOP = 4'h9
  } ssq_op_t;
endpackage

// File: logic/ssq_core.sv
// sequencer stacks and core computational registers
`timescale 1ns/1ps
module ssq_core #(
  parameter int PC_DEPTH   = ssq_pkg::PC_DEPTH,
  parameter int LOOP_DEPTH = ssq_pkg::LOOP_DEPTH,
  parameter int CNT_DEPTH  = ssq_pkg::CNT_DEPTH
) (
  input  wire logic            clock_i,
  input  wire logic            reset_i,
  input  wire logic            clk_en_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  input  wire logic [1:0]      reg_grp_i,
  input  wire logic [3:0]      reg_addr_i,
  input  wire logic [15:0]     reg_wdata_i,
  output logic [15:0]          reg_rdata_o,
  input  wire ssq_pkg::ssq_op_t op_i,
  input  wire logic [23:0]     pc_i,
  input  wire logic [23:0]     loop_end_i,
  input  wire logic            loop_iter_i,
  output logic                 pc_load_o,
  output logic [23:0]          pc_target_o,
  output logic                 pc_empty_o,
  output logic                 pc_full_o,
  output logic                 loop_empty_o,
  output logic                 loop_full_o,
  output logic                 cnt_empty_o,
  output logic                 cnt_full_o,
  output logic [2:0]           overflow_o,
  input  wire logic            multi_i,
  input  wire logic [3:0]      ax_sel_i,
  input  wire logic [3:0]      ay_sel_i,
  input  wire logic [3:0]      mx_sel_i,
  input  wire logic [3:0]      my_sel_i,
  input  wire logic [3:0]      sh_sel_i,
  output logic [15:0]          alu_x_o,
  output logic [15:0]          alu_y_o,
  output logic [15:0]          mul_x_o,
  output logic [15:0]          mul_y_o,
  output logic [15:0]          sh_in_o,
  input  wire logic            alu_wr_i,
  input  wire logic            alu_to_af_i,
  input  wire logic [15:0]     alu_res_i,
  input  wire logic            mac_wr_i,
  input  wire logic            mac_to_sr_i,
  input  wire logic [39:0]     mac_res_i,
  input  wire logic            sh_wr_i,
  input  wire logic [39:0]     sh_res_i,
  input  wire logic            se_wr_i,
  input  wire logic [7:0]      se_val_i,
  input  wire logic            sb_wr_i,
  input  wire logic [4:0]      sb_val_i,
  output logic [39:0]          mac_acc_o,
  output logic [7:0]           sh_exp_o,
  output logic [4:0]           blk_exp_o
);
  localparam int PW = $clog2(PC_DEPTH + 1);
  localparam int LW = $clog2(LOOP_DEPTH + 1);
  localparam int CW = $clog2(CNT_DEPTH + 1);
  localparam int SE_MSB = ssq_pkg::SE_W - 1;
  localparam int SB_MSB = ssq_pkg::SB_W - 1;

  typedef struct packed {
    logic [PC_DEPTH-1:0][23:0]   pmem;
    logic [PW-1:0]               pcnt;
    logic [23:0]                 ptop;
    logic [LOOP_DEPTH-1:0][23:0] lmem;
    logic [LW-1:0]               lcnt;
    logic [23:0]                 ltop;
    logic [CNT_DEPTH-1:0][15:0]  cmem;
    logic [CW-1:0]               ccnt;
    logic [15:0]                 ctop;
    logic [15:0][15:0]           dreg;
    logic [15:0]                 af;
    logic [15:0]                 se;
    logic [15:0]                 sb;
    logic [15:0]                 px;
    logic [15:0]                 irq_mask_reg;
    logic [15:0]                 irq_latch_reg;
    logic [15:0]                 irq_control_reg;
    logic [7:0]                  indirect_jump_page;
    logic [15:0]                 loop_counter;
    logic [15:0]                 rdata;
    logic                        pc_ld;
    logic [23:0]                 pc_tgt;
    logic [5:0]                  flags;
    logic [2:0]                  ovf;
    logic [15:0]                 ax;
    logic [15:0]                 ay;
    logic [15:0]                 mx;
    logic [15:0]                 my;
    logic [15:0]                 shin;
    logic [39:0]                 acc;
  } ssq_state_t;

  ssq_state_t q;
  ssq_state_t n;

  // next state: register port first, then the sequencer op, so an op wins
  always_comb begin
    n = q;
    n.pc_ld = 1'b0;
    if (reg_rd_i) begin
      n.rdata = 16'h0000;
      case (reg_grp_i)
        ssq_pkg::G_DREG: n.rdata = q.dreg[reg_addr_i];
        ssq_pkg::G_REG1: begin
          case (reg_addr_i)
            ssq_pkg::A_IRQ_MASK_REG: n.rdata = q.irq_mask_reg;
            ssq_pkg::A_IRQ_LATCH_REG: n.rdata = q.irq_latch_reg;
            ssq_pkg::A_IRQ_CONTROL_REG: n.rdata = q.irq_control_reg;
            ssq_pkg::A_PADDR: n.rdata = q.ptop[15:0];
            default: n.rdata = 16'h0000;
          endcase
        end
        ssq_pkg::G_REG2: begin
          case (reg_addr_i)
            ssq_pkg::A_LOOP_COUNTER:  n.rdata = q.loop_counter;
            ssq_pkg::A_LADDR: n.rdata = q.ltop[15:0];
            default: n.rdata = 16'h0000;
          endcase
        end
        default: begin
          case (reg_addr_i)
            ssq_pkg::A_LPAGE: n.rdata = {8'h00, q.ltop[23:16]};
            ssq_pkg::A_SE:    n.rdata = q.se;
            ssq_pkg::A_SB:    n.rdata = q.sb;
            ssq_pkg::A_PX:    n.rdata = q.px;
            ssq_pkg::A_INDIRECT_JUMP_PAGE:  n.rdata = {8'h00, q.indirect_jump_page};
            ssq_pkg::A_PPAGE: n.rdata = {8'h00, q.ptop[23:16]};
            default: n.rdata = 16'h0000;
          endcase
        end
      endcase
    end
    // software writes; the loop stack top is staging for explicit pushes, while pc pushes take pc_i
    if (reg_wr_i) begin
      case (reg_grp_i)
        ssq_pkg::G_DREG: n.dreg[reg_addr_i] = reg_wdata_i;
        ssq_pkg::G_REG1: begin
          case (reg_addr_i)
            ssq_pkg::A_IRQ_MASK_REG: n.irq_mask_reg = reg_wdata_i;
            ssq_pkg::A_IRQ_LATCH_REG: n.irq_latch_reg = reg_wdata_i;
            ssq_pkg::A_IRQ_CONTROL_REG: n.irq_control_reg = reg_wdata_i;
            ssq_pkg::A_PADDR: n.ptop[15:0] = reg_wdata_i;
            default: n.irq_mask_reg = q.irq_mask_reg;
          endcase
        end
        ssq_pkg::G_REG2: begin
          case (reg_addr_i)
            ssq_pkg::A_LOOP_COUNTER:  n.loop_counter = reg_wdata_i;
            ssq_pkg::A_LADDR: n.ltop[15:0] = reg_wdata_i;
            default: n.loop_counter = q.loop_counter;
          endcase
        end
        default: begin
          case (reg_addr_i)
            ssq_pkg::A_LPAGE: n.ltop[23:16] = reg_wdata_i[7:0];
            ssq_pkg::A_SE:    n.se = reg_wdata_i;
            ssq_pkg::A_SB:    n.sb = reg_wdata_i;
            ssq_pkg::A_PX:    n.px = reg_wdata_i;
            ssq_pkg::A_INDIRECT_JUMP_PAGE:  n.indirect_jump_page = reg_wdata_i[7:0];
            ssq_pkg::A_PPAGE: n.ptop[23:16] = reg_wdata_i[7:0];
            default: n.px = q.px;
          endcase
        end
      endcase
    end
    // computation results land only in their own registers, never px
    if (alu_wr_i) begin
      if (alu_to_af_i) begin
        n.af = alu_res_i;
      end else begin
        n.dreg[ssq_pkg::A_AR] = alu_res_i;
      end
    end
    if (sh_wr_i) begin
      n.dreg[ssq_pkg::A_SR2] = {{8{sh_res_i[39]}}, sh_res_i[39:32]};
      n.dreg[ssq_pkg::A_SR1] = sh_res_i[31:16];
      n.dreg[ssq_pkg::A_SR0] = sh_res_i[15:0];
    end
    // dual accumulator: multiplier may target the shift result instead
    if (mac_wr_i) begin
      if (mac_to_sr_i) begin
        n.dreg[ssq_pkg::A_SR2] = {{8{mac_res_i[39]}}, mac_res_i[39:32]};
        n.dreg[ssq_pkg::A_SR1] = mac_res_i[31:16];
        n.dreg[ssq_pkg::A_SR0] = mac_res_i[15:0];
      end else begin
        n.dreg[ssq_pkg::A_MR2] = {{8{mac_res_i[39]}}, mac_res_i[39:32]};
        n.dreg[ssq_pkg::A_MR1] = mac_res_i[31:16];
        n.dreg[ssq_pkg::A_MR0] = mac_res_i[15:0];
      end
    end
    // shifter keeps only the narrow signed field, sign-extended to 16
    if (se_wr_i) begin
      n.se = {{8{se_val_i[SE_MSB]}}, se_val_i};
    end
    if (sb_wr_i) begin
      n.sb = {{11{sb_val_i[SB_MSB]}}, sb_val_i};
    end
    // sequencer ops; a push into a full stack is dropped and flagged
    case (op_i)
      ssq_pkg::OP_JUMP, ssq_pkg::OP_CALL, ssq_pkg::OP_PUSH_PC, ssq_pkg::OP_LOOP: begin
        if (q.pcnt == PW'(PC_DEPTH)) begin
          n.ovf[0] = 1'b1;
        end else begin
          n.pmem[q.pcnt] = pc_i;
          n.pcnt = q.pcnt + 1'b1;
          n.ptop = pc_i;
        end
        if (op_i == ssq_pkg::OP_LOOP) begin
          if (q.lcnt == LW'(LOOP_DEPTH)) begin
            n.ovf[1] = 1'b1;
          end else begin
            n.lmem[q.lcnt] = loop_end_i;
            n.lcnt = q.lcnt + 1'b1;
            n.ltop = loop_end_i;
          end
          if (q.ccnt == CW'(CNT_DEPTH)) begin
            n.ovf[2] = 1'b1;
          end else begin
            n.cmem[q.ccnt] = n.loop_counter;
            n.ccnt = q.ccnt + 1'b1;
            n.ctop = n.loop_counter;
          end
        end
      end
      ssq_pkg::OP_RTS, ssq_pkg::OP_RTI, ssq_pkg::OP_POP_PC: begin
        if (q.pcnt != '0) begin
          n.pc_ld = 1'b1;
          n.pc_tgt = q.ptop;
          n.pcnt = q.pcnt - 1'b1;
          n.ptop = (q.pcnt > PW'(1)) ? q.pmem[q.pcnt - PW'(2)] : 24'h000000;
        end
      end
      ssq_pkg::OP_PUSH_LOOP: begin
        // pushes the staged top exactly as software left it
        if (q.lcnt == LW'(LOOP_DEPTH)) begin
          n.ovf[1] = 1'b1;
        end else begin
          n.lmem[q.lcnt] = n.ltop;
          n.lcnt = q.lcnt + 1'b1;
        end
        if (q.ccnt == CW'(CNT_DEPTH)) begin
          n.ovf[2] = 1'b1;
        end else begin
          n.cmem[q.ccnt] = n.loop_counter;
          n.ccnt = q.ccnt + 1'b1;
          n.ctop = n.loop_counter;
        end
      end
      ssq_pkg::OP_POP_LOOP: begin
        if (q.lcnt != '0) begin
          n.lcnt = q.lcnt - 1'b1;
          n.ltop = (q.lcnt > LW'(1)) ? q.lmem[q.lcnt - LW'(2)] : 24'h000000;
        end
      end
      default: begin
        // loop end reached: iterate, or on the last pass leave the loop
        if (loop_iter_i && q.ccnt != '0) begin
          n.pc_ld = 1'b1;
          if (q.ctop == 16'h0001) begin
            n.pc_tgt = q.ltop + 24'h000001;
            n.ccnt = q.ccnt - 1'b1;
            n.ctop = (q.ccnt > CW'(1)) ? q.cmem[q.ccnt - CW'(2)] : 16'h0000;
            if (q.lcnt != '0) begin
              n.lcnt = q.lcnt - 1'b1;
              n.ltop = (q.lcnt > LW'(1)) ? q.lmem[q.lcnt - LW'(2)] : 24'h000000;
            end
            if (q.pcnt != '0) begin
              n.pcnt = q.pcnt - 1'b1;
              n.ptop = (q.pcnt > PW'(1)) ? q.pmem[q.pcnt - PW'(2)] : 24'h000000;
            end
          end else begin
            n.pc_tgt = q.ptop;
            n.ctop = q.ctop - 16'h0001;
          end
        end
      end
    endcase
    // flags follow the next depths so they stand beside the stacks
    n.flags[0] = (n.pcnt == '0);
    n.flags[1] = (n.pcnt == PW'(PC_DEPTH));
    n.flags[2] = (n.lcnt == '0);
    n.flags[3] = (n.lcnt == LW'(LOOP_DEPTH));
    n.flags[4] = (n.ccnt == '0);
    n.flags[5] = (n.ccnt == CW'(CNT_DEPTH));
    // operand routing: multifunction ops see only the dedicated inputs
    if (multi_i) begin
      n.ax = ax_sel_i[0] ? q.dreg[ssq_pkg::A_AX1] : q.dreg[ssq_pkg::A_AX0];
      n.ay = ay_sel_i[0] ? q.dreg[ssq_pkg::A_AY1] : q.dreg[ssq_pkg::A_AY0];
      n.mx = mx_sel_i[0] ? q.dreg[ssq_pkg::A_MX1] : q.dreg[ssq_pkg::A_MX0];
      n.my = my_sel_i[0] ? q.dreg[ssq_pkg::A_MY1] : q.dreg[ssq_pkg::A_MY0];
      n.shin = q.dreg[ssq_pkg::A_SI];
    end else begin
      n.ax = q.dreg[ax_sel_i];
      n.ay = q.dreg[ay_sel_i];
      n.mx = q.dreg[mx_sel_i];
      n.my = q.dreg[my_sel_i];
      n.shin = q.dreg[sh_sel_i];
    end
    // accumulator view is registered from the next state, so it shows a result written this cycle
    n.acc = mac_to_sr_i ? {n.dreg[ssq_pkg::A_SR2][7:0], n.dreg[ssq_pkg::A_SR1], n.dreg[ssq_pkg::A_SR0]}
                        : {n.dreg[ssq_pkg::A_MR2][7:0], n.dreg[ssq_pkg::A_MR1], n.dreg[ssq_pkg::A_MR0]};
  end

  // single state register; clock enable freezes everything but reset
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      q <= '0;
      q.irq_mask_reg <= ssq_pkg::IRQ_RST;
      q.irq_latch_reg <= ssq_pkg::IRQ_RST;
      q.irq_control_reg <= ssq_pkg::IRQ_RST;
      q.indirect_jump_page <= ssq_pkg::INDIRECT_JUMP_PAGE_RST;
      q.flags <= 6'h15;
    end else if (clk_en_i) begin
      q <= n;
    end
  end

  // outputs are plain slices of the state register
  assign reg_rdata_o  = q.rdata;
  assign pc_load_o    = q.pc_ld;
  assign pc_target_o  = q.pc_tgt;
  assign pc_empty_o   = q.flags[0];
  assign pc_full_o    = q.flags[1];
  assign loop_empty_o = q.flags[2];
  assign loop_full_o  = q.flags[3];
  assign cnt_empty_o  = q.flags[4];
  assign cnt_full_o   = q.flags[5];
  assign overflow_o   = q.ovf;
  assign alu_x_o      = q.ax;
  assign alu_y_o      = q.ay;
  assign mul_x_o      = q.mx;
  assign mul_y_o      = q.my;
  assign sh_in_o      = q.shin;
  assign mac_acc_o    = q.acc;
  assign sh_exp_o     = q.se[SE_MSB:0];
  assign blk_exp_o    = q.sb[SB_MSB:0];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_pc_push;
    clk_en_i && !q.flags[1] && (op_i == ssq_pkg::OP_CALL || op_i == ssq_pkg::OP_PUSH_PC);
  endsequence
  sequence s_last_pass;
    clk_en_i && op_i == ssq_pkg::OP_NONE && loop_iter_i && q.ccnt != '0 && q.ctop == 16'h0001;
  endsequence

  a_pc_push_top: assert property (s_pc_push |=> q.ptop == $past(pc_i) && q.pcnt == $past(q.pcnt) + 1'b1)
    else $error("pc push did not update top");
  a_pc_pop_load: assert property (clk_en_i && !q.flags[0] && op_i == ssq_pkg::OP_RTS
    |=> pc_load_o && pc_target_o == $past(q.ptop) && q.pcnt == $past(q.pcnt) - 1'b1)
    else $error("pc pop did not load pc");
  a_pc_depth_cap: assert property (q.pcnt <= PW'(PC_DEPTH) && pc_full_o == (q.pcnt == PW'(PC_DEPTH)))
    else $error("pc stack depth wrong");
  a_loop_push_end: assert property (clk_en_i && !q.flags[3] && !q.flags[1] && op_i == ssq_pkg::OP_LOOP
    |=> q.ltop == $past(loop_end_i) && q.ptop == $past(pc_i))
    else $error("loop start push wrong");
  a_loop_depth_cap: assert property (q.lcnt <= LW'(LOOP_DEPTH) && loop_full_o == (q.lcnt == LW'(LOOP_DEPTH)))
    else $error("loop stack depth wrong");
  a_loop_exit_pc: assert property (s_last_pass |=> pc_load_o && pc_target_o == $past(q.ltop) + 24'h000001)
    else $error("loop exit target wrong");
  a_push_loop_keep: assert property (clk_en_i && !reg_wr_i && !q.flags[3] && op_i == ssq_pkg::OP_PUSH_LOOP
    |=> q.ltop == $past(q.ltop) && q.lcnt == $past(q.lcnt) + 1'b1)
    else $error("push loop changed top");
  a_pop_loop_drop: assert property (clk_en_i && !q.flags[2] && op_i == ssq_pkg::OP_POP_LOOP
    |=> q.lcnt == $past(q.lcnt) - 1'b1)
    else $error("pop loop left depth");
  a_cnt_push_val: assert property (clk_en_i && !reg_wr_i && !q.flags[5] && op_i == ssq_pkg::OP_LOOP
    |=> q.ctop == $past(q.loop_counter))
    else $error("counter stack not loaded");
  a_alu_dest_sel: assert property (clk_en_i && alu_wr_i && !alu_to_af_i && !reg_wr_i
    |=> q.dreg[ssq_pkg::A_AR] == $past(alu_res_i))
    else $error("alu result misplaced");
  a_irq_reset_val: assert property (disable iff (1'b0) reset_i
    |=> q.irq_mask_reg == 16'h0000 && q.irq_latch_reg == 16'h0000 && q.irq_control_reg == 16'h0000 && q.indirect_jump_page == 8'h00)
    else $error("reset values wrong");
endmodule

// File: bench/ssq_dp_model.sv
// datapath partner model: turns the operand outputs into result inputs
`timescale 1ns/1ps
module ssq_dp_model (
  input  wire logic [15:0] ax_i,
  input  wire logic [15:0] ay_i,
  input  wire logic [15:0] mx_i,
  input  wire logic [15:0] my_i,
  input  wire logic [15:0] si_i,
  output logic [15:0]      alu_o,
  output logic [39:0]      mac_o,
  output logic [39:0]      sh_o
);
  logic signed [31:0] prod;
  // results are combinational so they line up with the write strobe of the same cycle
  assign prod  = $signed(mx_i) * $signed(my_i);
  assign alu_o = ax_i + ay_i;
  assign mac_o = {{8{prod[31]}}, prod};
  // shift input lands in the middle word so the top word shows sign extension
  assign sh_o  = {{8{si_i[15]}}, si_i, 16'h0000};
endmodule

// File: bench/tb_top.sv
// self-checking bench for the sequencer stack and core register block
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [1:0] g; logic [3:0] a; logic [15:0] d; logic [15:0] e;} ssq_row_t;
  logic             clock_i, reset_i, clk_en_i, reg_wr_i, reg_rd_i, loop_iter_i, multi_i;
  logic             alu_wr_i, alu_to_af_i, mac_wr_i, mac_to_sr_i, sh_wr_i, se_wr_i, sb_wr_i;
  logic             pc_load_o, pc_empty_o, pc_full_o, loop_empty_o, loop_full_o, cnt_empty_o, cnt_full_o;
  logic [1:0]       reg_grp_i;
  logic [3:0]       reg_addr_i, ax_sel_i, ay_sel_i, mx_sel_i, my_sel_i, sh_sel_i;
  logic [15:0]      reg_wdata_i, reg_rdata_o, alu_x_o, alu_y_o, mul_x_o, mul_y_o, sh_in_o, alu_res_i;
  logic [23:0]      pc_i, loop_end_i, pc_target_o;
  logic [39:0]      mac_res_i, sh_res_i, mac_acc_o;
  logic [7:0]       se_val_i, sh_exp_o;
  logic [4:0]       sb_val_i, blk_exp_o;
  logic [2:0]       overflow_o;
  ssq_pkg::ssq_op_t op_i;
  ssq_pkg::ssq_op_t pu [3];
  ssq_pkg::ssq_op_t po [3];
  ssq_row_t         rows [7];
  int               n_errors, compares;

  ssq_core uut (
    .clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_grp_i(reg_grp_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .op_i(op_i), .pc_i(pc_i), .loop_end_i(loop_end_i), .loop_iter_i(loop_iter_i), .pc_load_o(pc_load_o),
    .pc_target_o(pc_target_o), .pc_empty_o(pc_empty_o), .pc_full_o(pc_full_o), .loop_empty_o(loop_empty_o),
    .loop_full_o(loop_full_o), .cnt_empty_o(cnt_empty_o), .cnt_full_o(cnt_full_o), .overflow_o(overflow_o),
    .multi_i(multi_i), .ax_sel_i(ax_sel_i), .ay_sel_i(ay_sel_i), .mx_sel_i(mx_sel_i), .my_sel_i(my_sel_i),
    .sh_sel_i(sh_sel_i), .alu_x_o(alu_x_o), .alu_y_o(alu_y_o), .mul_x_o(mul_x_o), .mul_y_o(mul_y_o),
    .sh_in_o(sh_in_o), .alu_wr_i(alu_wr_i), .alu_to_af_i(alu_to_af_i), .alu_res_i(alu_res_i),
    .mac_wr_i(mac_wr_i), .mac_to_sr_i(mac_to_sr_i), .mac_res_i(mac_res_i), .sh_wr_i(sh_wr_i),
    .sh_res_i(sh_res_i), .se_wr_i(se_wr_i), .se_val_i(se_val_i), .sb_wr_i(sb_wr_i), .sb_val_i(sb_val_i),
    .mac_acc_o(mac_acc_o), .sh_exp_o(sh_exp_o), .blk_exp_o(blk_exp_o));
  ssq_dp_model u_dp (.ax_i(alu_x_o), .ay_i(alu_y_o), .mx_i(mul_x_o), .my_i(mul_y_o), .si_i(sh_in_o),
                     .alu_o(alu_res_i), .mac_o(mac_res_i), .sh_o(sh_res_i));

  // inputs always change 1 ns after the rising edge
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // every strobe is assigned once per cycle, so back-to-back requests never glitch
  task automatic drv(input logic wr, input logic rd, input ssq_pkg::ssq_op_t o, input logic it);
    reg_wr_i    = wr;
    reg_rd_i    = rd;
    op_i        = o;
    loop_iter_i = it;
    tick();
  endtask
  task automatic acc(input logic [1:0] g, input logic [3:0] a, input logic [15:0] d, input logic wr);
    reg_grp_i   = g;
    reg_addr_i  = a;
    reg_wdata_i = d;
    drv(wr, !wr, ssq_pkg::OP_NONE, 1'b0);
  endtask
  // read data is registered, so it is valid right after the taking edge
  task automatic rd_chk(input logic [1:0] g, input logic [3:0] a, input logic [15:0] e);
    acc(g, a, 16'h0000, 1'b0);
    chk(reg_rdata_o, e);
  endtask
  task automatic do_op(input ssq_pkg::ssq_op_t o, input logic [23:0] pc, input logic [23:0] le);
    pc_i       = pc;
    loop_end_i = le;
    drv(1'b0, 1'b0, o, 1'b0);
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // hang guard: a run this long means something stalled
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    end_sim();
  end

  initial begin
    int k;
    reset_i  = 1'b1;
    clk_en_i = 1'b1;
    op_i     = ssq_pkg::OP_NONE;
    {reg_wr_i, reg_rd_i, loop_iter_i, multi_i, alu_wr_i, alu_to_af_i} = '0;
    {mac_wr_i, mac_to_sr_i, sh_wr_i, se_wr_i, sb_wr_i} = '0;
    {reg_grp_i, reg_addr_i, reg_wdata_i, pc_i, loop_end_i, se_val_i, sb_val_i} = '0;
    {ax_sel_i, ay_sel_i, mx_sel_i, my_sel_i, sh_sel_i} = '0;
    pu   = '{ssq_pkg::OP_JUMP, ssq_pkg::OP_CALL, ssq_pkg::OP_PUSH_PC};
    po   = '{ssq_pkg::OP_RTS, ssq_pkg::OP_RTI, ssq_pkg::OP_POP_PC};
    rows = '{'{2'h0, 4'h0, 16'h1234, 16'h1234}, '{2'h0, 4'hA, 16'hBEEF, 16'hBEEF},
             '{2'h1, 4'hC, 16'h0F0F, 16'h0F0F}, '{2'h1, 4'hD, 16'hA5A5, 16'hA5A5},
             '{2'h1, 4'hE, 16'h00FF, 16'h00FF}, '{2'h3, 4'hB, 16'h125A, 16'h005A},
             '{2'h2, 4'hC, 16'hFFFF, 16'h0000}};
    repeat (2) @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    // reset state of flags and interrupt and page registers
    chk({pc_empty_o, pc_full_o, loop_empty_o, loop_full_o, cnt_empty_o, cnt_full_o, pc_load_o, overflow_o},
        10'h2A0);
    rd_chk(2'h1, 4'hC, 16'h0000);
    rd_chk(2'h1, 4'hD, 16'h0000);
    rd_chk(2'h1, 4'hE, 16'h0000);
    rd_chk(2'h3, 4'hB, 16'h0000);
    // register rows: write then read back; the last row is an unmapped slot
    for (k = 0; k < 7; k++) begin
      acc(rows[k].g, rows[k].a, rows[k].d, 1'b1);
      rd_chk(rows[k].g, rows[k].a, rows[k].e);
    end
    // call then return through the pc stack top registers
    do_op(ssq_pkg::OP_CALL, 24'hAB1234, 24'h000000);
    chk(pc_empty_o, 1'b0);
    rd_chk(2'h1, 4'hF, 16'h1234);
    rd_chk(2'h3, 4'hF, 16'h00AB);
    do_op(ssq_pkg::OP_RTS, 24'h000000, 24'h000000);
    chk({pc_load_o, pc_target_o, pc_empty_o}, {1'b1, 24'hAB1234, 1'b1});
    // fill the pc stack back to back, one push beyond its depth
    for (k = 0; k < 34; k++) begin
      do_op(pu[k % 3], {k[7:0], 8'h5A, k[7:0]}, 24'h000000);
      if (k == 31) chk(pc_full_o, 1'b0);
    end
    chk({pc_full_o, overflow_o}, 4'h9);
    for (k = 32; k >= 0; k--) begin
      do_op(po[k % 3], 24'h000000, 24'h000000);
      chk({pc_load_o, pc_target_o}, {1'b1, k[7:0], 8'h5A, k[7:0]});
    end
    chk(pc_empty_o, 1'b1);
    do_op(ssq_pkg::OP_POP_PC, 24'h000000, 24'h000000);
    chk(pc_load_o, 1'b0);
    // counter loop of two passes
    acc(2'h2, 4'hE, 16'h0002, 1'b1);
    do_op(ssq_pkg::OP_LOOP, 24'h030010, 24'h040020);
    chk({loop_empty_o, cnt_empty_o, pc_empty_o}, 3'h0);
    rd_chk(2'h2, 4'hF, 16'h0020);
    rd_chk(2'h3, 4'h3, 16'h0004);
    drv(1'b0, 1'b0, ssq_pkg::OP_NONE, 1'b1);
    chk({pc_load_o, pc_target_o, loop_empty_o}, {1'b1, 24'h030010, 1'b0});
    drv(1'b0, 1'b0, ssq_pkg::OP_NONE, 1'b1);
    chk({pc_load_o, pc_target_o, loop_empty_o, cnt_empty_o, pc_empty_o}, {1'b1, 24'h040021, 3'h7});
    // software-staged loop pushes until refused
    for (k = 1; k < 10; k++) begin
      if (k < 9) begin
        acc(2'h2, 4'hE, 16'(k), 1'b1);
        acc(2'h3, 4'h3, {8'h00, k[7:0]}, 1'b1);
        acc(2'h2, 4'hF, {k[7:0], 8'hC3}, 1'b1);
      end
      do_op(ssq_pkg::OP_PUSH_LOOP, 24'h000000, 24'h000000);
      if (k == 7) chk({loop_full_o, cnt_full_o}, 2'h0);
    end
    chk({loop_full_o, cnt_full_o, overflow_o}, 5'h1F);
    do_op(ssq_pkg::OP_POP_LOOP, 24'h000000, 24'h000000);
    rd_chk(2'h2, 4'hF, 16'h07C3);
    rd_chk(2'h3, 4'h3, 16'h0007);
    for (k = 0; k < 7; k++) do_op(ssq_pkg::OP_POP_LOOP, 24'h000000, 24'h000000);
    chk(loop_empty_o, 1'b1);
    // operand routing, single-function then multifunction
    acc(2'h0, 4'h1, 16'h1111, 1'b1);
    acc(2'h0, 4'h4, 16'h0002, 1'b1);
    acc(2'h0, 4'h3, 16'h0004, 1'b1);
    acc(2'h0, 4'h7, 16'hFFFE, 1'b1);
    acc(2'h0, 4'hB, 16'h8001, 1'b1);
    ax_sel_i = 4'hA;
    tick();
    chk(alu_x_o, 16'hBEEF);
    multi_i = 1'b1;
    {ax_sel_i, ay_sel_i, mx_sel_i, my_sel_i, sh_sel_i} = 20'h10110;
    tick();
    chk({alu_x_o, alu_y_o}, 32'h11110002);
    chk({mul_x_o, mul_y_o}, 32'h0004FFFE);
    chk(sh_in_o, 16'h8001);
    // alu result to result register, then diverted to feedback
    alu_wr_i = 1'b1;
    tick();
    alu_wr_i = 1'b0;
    rd_chk(2'h0, 4'hA, 16'h1113);
    {alu_wr_i, alu_to_af_i} = 2'h3;
    tick();
    {alu_wr_i, sh_wr_i} = 2'h1;
    tick();
    sh_wr_i = 1'b0;
    rd_chk(2'h0, 4'hA, 16'h1113);
    rd_chk(2'h0, 4'hD, 16'h8001);
    rd_chk(2'h0, 4'h9, 16'hFFFF);
    {mac_wr_i, mac_to_sr_i} = 2'h3;
    tick();
    mac_wr_i = 1'b0;
    chk(mac_acc_o, 40'hFFFFFFFFF8);
    mac_to_sr_i = 1'b0;
    tick();
    chk(mac_acc_o, 40'h0000000000);
    // exponents keep only their low bits, signed
    {se_wr_i, sb_wr_i, se_val_i, sb_val_i} = {2'h3, 8'hF0, 5'h13};
    tick();
    {se_wr_i, sb_wr_i} = 2'h0;
    chk({sh_exp_o, blk_exp_o}, {8'hF0, 5'h13});
    rd_chk(2'h3, 4'h5, 16'hFFF0);
    rd_chk(2'h3, 4'h6, 16'hFFF3);
    // clock enable low freezes the stacks: a call is not taken
    clk_en_i = 1'b0;
    do_op(ssq_pkg::OP_CALL, 24'h123456, 24'h000000);
    chk(pc_empty_o, 1'b1);
    clk_en_i = 1'b1;
    // a second reset clears the sticky overflow bits
    reset_i = 1'b1;
    tick();
    reset_i = 1'b0;
    chk({overflow_o, pc_empty_o, loop_empty_o}, 5'h03);
    rd_chk(2'h1, 4'hC, 16'h0000);
    end_sim();
  end
endmodule
